// ### common/rq_sideband_params.svh
`ifndef RQ_SIDEBAND_PARAMS_SVH
`define RQ_SIDEBAND_PARAMS_SVH

// ----------------------------------------------------------------
// Sideband bus field positions
// ----------------------------------------------------------------
`define SB_WIDTH 60
`define SB_OFFSET_LO 8
`define SB_OFFSET_HI 10
`define SB_ABORT_BIT 11
`define SB_HINT_BIT 12
`define SB_KIND_LO 13
`define SB_KIND_HI 14

// ----------------------------------------------------------------
// Stream and register map
// ----------------------------------------------------------------
`define PAYLOAD_WIDTH 256
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_HEADER 8'h08
`define REG_COUNT 8'h0C
`define CTRL_RESET 32'h0000_0000
`define CTRL_ENDPOINT_BIT 0
`define CTRL_ADDR_ALIGN_BIT 1
`define IDLE_DATA 32'h0000_0000

`endif

// ### common/rq_sideband_pkg.sv
package rq_sideband_pkg;

    // Request header fields taken from the first beat.
    typedef struct packed {
        logic       hintPresent;
        logic [1:0] hintKind;
        logic [2:0] laneOffset;
    } req_header_s;

    // Per-packet outcome handed to the link side.
    typedef struct packed {
        logic        nullify;
        logic        errorReport;
        req_header_s header;
    } req_result_s;

    typedef enum logic [1:0] {
        PKT_IDLE  = 2'b00,
        PKT_BODY  = 2'b01,
        PKT_ABORT = 2'b10
    } pkt_state_e;

endpackage

// ### core/wb_reg_slave.sv
`include "rq_sideband_params.svh"

module wb_reg_slave
    import rq_sideband_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Wishbone classic slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [7:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatW,
    output logic      [31:0] wbDatR,
    output logic             wbAck,
    // Block side
    output logic      [31:0] ctrl_r,
    input  wire logic [31:0] statusWord,
    input  wire logic [31:0] headerWord,
    input  wire logic [31:0] countWord
);

    logic req;
    assign req = wbCyc && wbStb && !wbAck;

    // Ack one cycle after the request; dropped the cycle after.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wbAck <= 1'b0;
        end else begin
            wbAck <= req;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `CTRL_RESET;
        end else if (req && wbWe && wbAdr == `REG_CTRL) begin
            for (int i = 0; i < 4; i++) begin
                if (wbSel[i]) begin
                    ctrl_r[i*8 +: 8] <= wbDatW[i*8 +: 8];
                end
            end
        end
    end

    // Unmapped addresses read as zero and accept writes silently.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wbDatR <= `IDLE_DATA;
        end else if (req && !wbWe) begin
            unique case (wbAdr)
                `REG_CTRL:   wbDatR <= ctrl_r;
                `REG_STATUS: wbDatR <= statusWord;
                `REG_HEADER: wbDatR <= headerWord;
                `REG_COUNT:  wbDatR <= countWord;
                default:     wbDatR <= `IDLE_DATA;
            endcase
        end
    end

endmodule

// ### core/rq_sideband_capture.sv
// Behaviour
// - capture offset and hint fields on first beat
// - abort nullifies the packet on the link
// - abort stays latched until packet end
// - abort only with valid, sampled with ready
// - endpoint reports aborted request through error reporting
// - hint present flag inserts a processing hint
// - hint kind copied into PH field
// - hint kind ignored without hint flag
//
// The register offsets and the Wishbone slave port were decided locally.
`include "rq_sideband_params.svh"

module rq_sideband_capture
    import rq_sideband_pkg::*;
(
    // Clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_b,
    // Request stream from the user application
    input  wire logic                        request_stream_valid,
    input  wire logic                        requestStreamLast,
    input  wire logic [`PAYLOAD_WIDTH-1:0]   request_stream_payload,
    input  wire logic [`SB_WIDTH-1:0]        request_sideband_bus,
    output logic                             request_stream_ready,
    // Link side
    input  wire logic                        linkReady,
    output logic                             linkValid,
    output logic                             linkLast,
    output logic [`PAYLOAD_WIDTH-1:0]        linkPayload,
    output req_header_s                      linkHeader,
    output logic                             linkNullify,
    output logic                             errorReportPulse,
    // Wishbone classic slave
    input  wire logic                        wbCyc,
    input  wire logic                        wbStb,
    input  wire logic                        wbWe,
    input  wire logic [7:0]                  wbAdr,
    input  wire logic [3:0]                  wbSel,
    input  wire logic [31:0]                 wbDatW,
    output logic      [31:0]                 wbDatR,
    output logic                             wbAck
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    pkt_state_e state_r;
    req_header_s held_r;
    logic abortSticky_r;
    logic [15:0] abortCount_r;
    logic [31:0] ctrl_r;
    logic endpointMode;
    logic addrAligned;
    logic beat;
    logic firstBeat;
    logic abortNow;
    req_header_s sampled;
    logic linkValidNext;
    logic abortedEnd;

    assign endpointMode = ctrl_r[`CTRL_ENDPOINT_BIT];
    assign addrAligned = ctrl_r[`CTRL_ADDR_ALIGN_BIT];

    assign beat = request_stream_valid && request_stream_ready;
    assign firstBeat = beat && (state_r == PKT_IDLE);
    // abort counts only on accepted, non-first beats.
    assign abortNow = beat && !firstBeat && request_sideband_bus[`SB_ABORT_BIT];
    // An aborted packet ends on its last accepted beat; an abort on a first beat never counts.
    assign abortedEnd = beat && requestStreamLast && !firstBeat && (abortNow || abortSticky_r);

    function automatic req_header_s decode_header(input logic [`SB_WIDTH-1:0] sb, input logic aligned);
        req_header_s h;
        h.hintPresent = sb[`SB_HINT_BIT];
        // Kind forced to zero without a hint so stale values never leak.
        h.hintKind = sb[`SB_HINT_BIT] ? sb[`SB_KIND_HI:`SB_KIND_LO] : 2'h0;
        // Offset is meaningless in Dword mode, so it is forced to zero there.
        h.laneOffset = aligned ? sb[`SB_OFFSET_HI:`SB_OFFSET_LO] : 3'h0;
        return h;
    endfunction

    assign sampled = decode_header(request_sideband_bus, addrAligned);

    // ----------------------------------------------------------------
    // Stream handshake
    // ----------------------------------------------------------------
    // The output stage is a single register and ready is itself registered, so ready is only
    // offered when that register is sure to be empty in the next cycle. A beat is never overwritten
    // before the link has taken it; the price is at most one accepted beat every other cycle.
    assign linkValidNext = beat || (linkValid && !linkReady);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            request_stream_ready <= 1'b0;
        end else begin
            request_stream_ready <= !linkValidNext;
        end
    end

    // ----------------------------------------------------------------
    // Packet state
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= PKT_IDLE;
        end else if (beat) begin
            unique case (state_r)
                PKT_IDLE:  state_r <= requestStreamLast ? PKT_IDLE : PKT_BODY;
                PKT_BODY:  state_r <= requestStreamLast ? PKT_IDLE : (abortNow ? PKT_ABORT : PKT_BODY);
                PKT_ABORT: state_r <= requestStreamLast ? PKT_IDLE : PKT_ABORT;
                default:   state_r <= PKT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            held_r <= '0;
        end else if (firstBeat) begin
            held_r <= sampled;
        end
    end

    // Sticky within the packet; cleared when the next packet starts.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            abortSticky_r <= 1'b0;
        end else if (firstBeat) begin
            abortSticky_r <= 1'b0;
        end else if (abortNow) begin
            abortSticky_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Link output stage
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            linkValid <= 1'b0;
        end else if (beat) begin
            linkValid <= 1'b1;
        end else if (linkReady) begin
            linkValid <= 1'b0;
        end
    end

    // Ending early on the abort beat is allowed; last closes the packet.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            linkLast <= 1'b0;
            linkPayload <= '0;
        end else if (beat) begin
            linkLast <= requestStreamLast;
            linkPayload <= request_stream_payload;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            linkHeader <= '0;
        end else if (beat) begin
            linkHeader <= firstBeat ? sampled : held_r;
        end
    end

    // Every beat from the abort beat on is nullified; earlier beats are not.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            linkNullify <= 1'b0;
        end else if (beat) begin
            linkNullify <= abortNow || (abortSticky_r && !firstBeat);
        end
    end

    // In endpoint mode, one error report per aborted packet, at its end.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            errorReportPulse <= 1'b0;
        end else begin
            errorReportPulse <= endpointMode && abortedEnd;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            abortCount_r <= 16'h0000;
        end else if (abortedEnd) begin
            abortCount_r <= abortCount_r + 16'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Status words
    // ----------------------------------------------------------------
    logic [31:0] statusWord;
    logic [31:0] headerWord;
    logic [31:0] countWord;

    // Unused upper bits read as zero.
    assign statusWord = {28'h0000000, abortSticky_r, 1'b0, state_r};
    assign headerWord = {26'h0, held_r};
    assign countWord = {16'h0000, abortCount_r};

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    wb_reg_slave regs (
        .clock(clock),
        .rst_b(rst_b),
        .wbCyc(wbCyc),
        .wbStb(wbStb),
        .wbWe(wbWe),
        .wbAdr(wbAdr),
        .wbSel(wbSel),
        .wbDatW(wbDatW),
        .wbDatR(wbDatR),
        .wbAck(wbAck),
        .ctrl_r(ctrl_r),
        .statusWord(statusWord),
        .headerWord(headerWord),
        .countWord(countWord)
    );

endmodule

// ### testbench/rq_sideband_properties.sv
`include "rq_sideband_params.svh"

module rq_sideband_checker
    import rq_sideband_pkg::*;
(
    // Clock, reset and stream
    input wire logic clock,
    input wire logic rst_b,
    input wire logic request_stream_valid,
    input wire logic requestStreamLast,
    input wire logic [`SB_WIDTH-1:0] request_sideband_bus,
    input wire logic request_stream_ready,
    // Link side
    input wire logic linkReady,
    input wire logic linkValid,
    input wire logic linkLast,
    input wire req_header_s linkHeader,
    input wire logic linkNullify
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic inPkt_r;
    logic take;
    logic outMid_r;
    logic outNull_r;
    req_header_s outHdr_r;
    assign take = request_stream_valid && request_stream_ready;
    // Last beat taken by the link: whether it was mid-packet, nullified, and its header.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            outMid_r <= 1'b0;
            outNull_r <= 1'b0;
            outHdr_r <= '0;
        end else if (linkValid && linkReady) begin
            outMid_r <= !linkLast;
            outNull_r <= linkNullify;
            outHdr_r <= linkHeader;
        end
    end
    // High from the first accepted beat until the last one is taken.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) inPkt_r <= 1'b0;
        else if (take) inPkt_r <= !requestStreamLast;
    end
    a_first_hint: assert property (
        take && !inPkt_r |=> linkHeader.hintPresent == $past(request_sideband_bus[12])
        && (!linkHeader.hintPresent || linkHeader.hintKind == $past(request_sideband_bus[14:13])))
        else $error("hint");
    a_kind_masked: assert property (
        linkValid && !linkHeader.hintPresent |-> linkHeader.hintKind == 2'h0) else $error("kind");
    a_header_hold: assert property (linkValid && outMid_r |-> linkHeader == outHdr_r) else $error("hold");
    a_stall_hold: assert property (
        linkValid && !linkReady |=> linkValid && $stable(linkHeader)) else $error("stall");
    a_ready_path: assert property (
        $past(rst_b) |-> request_stream_ready == $past(!(take || (linkValid && !linkReady)))) else $error("ready");
    a_no_overwrite: assert property (take |-> !linkValid || linkReady) else $error("overwrite");
    a_abort_take: assert property (
        take && inPkt_r && request_sideband_bus[11] |=> linkNullify) else $error("abort");
    a_abort_sticky: assert property (linkValid && outMid_r && outNull_r |-> linkNullify) else $error("sticky");
    a_first_clean: assert property (take && !inPkt_r |=> !linkNullify) else $error("first");
    c_hint: cover property (take && request_sideband_bus[12]);
    c_abort: cover property (take && inPkt_r && request_sideband_bus[11]);
    c_stall: cover property (linkValid && !linkReady);
endmodule

bind rq_sideband_capture rq_sideband_checker chk (.clock, .rst_b, .request_stream_valid, .requestStreamLast,
    .request_sideband_bus, .request_stream_ready, .linkReady, .linkValid, .linkLast, .linkHeader, .linkNullify);

// ### testbench/user_app_model.sv
`include "rq_sideband_params.svh"

module user_app_model
    import rq_sideband_pkg::*;
(
    // Commands from the bench
    input wire logic clock,
    input wire logic rst_b,
    input wire logic go,
    input wire req_header_s hdr,
    input wire logic [2:0] beats,
    input wire logic [2:0] abortAt,
    // Request stream
    input wire logic request_stream_ready,
    output logic request_stream_valid,
    output logic requestStreamLast,
    output logic [`PAYLOAD_WIDTH-1:0] request_stream_payload,
    output logic [`SB_WIDTH-1:0] request_sideband_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] beat_r;
    // Only posted requests are sent, so abort is always legal here.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            request_stream_valid <= 1'b0;
            requestStreamLast <= 1'b0;
            beat_r <= 3'h0;
            request_stream_payload <= '0;
            request_sideband_bus <= '0;
        end else if (!request_stream_valid && go) begin
            request_stream_valid <= 1'b1;
            beat_r <= 3'h1;
            requestStreamLast <= beats == 3'h1;
            request_stream_payload <= {8{32'hC0DE_0001}};
            request_sideband_bus <= {45'h0, hdr.hintKind, hdr.hintPresent, 1'b0, hdr.laneOffset, 8'h00};
        end else if (request_stream_valid && request_stream_ready) begin
            beat_r <= beat_r + 3'h1;
            requestStreamLast <= beat_r + 3'h1 == beats;
            request_stream_payload <= ~request_stream_payload;
            if (requestStreamLast) begin
                request_stream_valid <= 1'b0;
                // Idle sideband is junk, but abort stays low while valid is low.
                request_sideband_bus <= {~request_sideband_bus[59:12], 1'b0, ~request_sideband_bus[10:0]};
            end else begin
                // Later beats scramble the header fields; the abort flag lasts one beat.
                request_sideband_bus[14:8] <= {~request_sideband_bus[14:12], beat_r + 3'h1 == abortAt,
                    ~request_sideband_bus[10:8]};
            end
        end
    end
endmodule

// ### testbench/testbench.sv
`include "rq_sideband_params.svh"
`define CHK(n, e, g) totalChecks++; if ((g) !== (e)) begin badCount++; $display("unexpected %s exp %h got %h", n, e, g); end

module testbench
    import rq_sideband_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, rst_b, go, linkReady, stall, request_stream_valid, requestStreamLast, request_stream_ready;
    logic linkValid, linkLast, linkNullify, errorReportPulse, wbCyc, wbStb, wbWe, wbAck;
    logic firstOut, firstNull;
    logic [3:0] wbSel;
    logic [`PAYLOAD_WIDTH-1:0] payloadSeen;
    int nullCount, pulseCount, outCount, nulls, pulses, outs;
    logic [7:0] wbAdr;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [`PAYLOAD_WIDTH-1:0] request_stream_payload, linkPayload;
    logic [`SB_WIDTH-1:0] request_sideband_bus;
    logic [2:0] beats, abortAt;
    req_header_s hdr, linkHeader, hdrSeen;
    int badCount, totalChecks;

    rq_sideband_capture dut (.clock, .rst_b, .request_stream_valid, .requestStreamLast, .request_stream_payload,
        .request_sideband_bus, .request_stream_ready, .linkReady, .linkValid, .linkLast, .linkPayload, .linkHeader,
        .linkNullify, .errorReportPulse, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck);
    user_app_model app (.clock, .rst_b, .go, .hdr, .beats, .abortAt, .request_stream_ready, .request_stream_valid,
        .requestStreamLast, .request_stream_payload, .request_sideband_bus);

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    always @(posedge clock) linkReady <= stall ? ~linkReady : 1'b1;
    always @(posedge clock) begin
        if (!rst_b) begin
            firstOut <= 1'b1;
            nullCount <= 0;
            pulseCount <= 0;
            outCount <= 0;
        end else begin
            if (errorReportPulse) pulseCount <= pulseCount + 1;
            if (linkValid && linkReady) begin
                if (firstOut) hdrSeen <= linkHeader;
                if (firstOut) firstNull <= linkNullify;
                if (firstOut) payloadSeen <= linkPayload;
                if (linkNullify) nullCount <= nullCount + 1;
                outCount <= outCount + 1;
                firstOut <= linkLast;
            end
        end
    end

    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
        output logic [31:0] q);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= s;
        wbDatW <= d;
        do @(posedge clock); while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic send(input req_header_s h, input logic [2:0] n, input logic [2:0] a);
        int null0, pulse0, out0;
        null0 = nullCount;
        pulse0 = pulseCount;
        out0 = outCount;
        hdr <= h;
        beats <= n;
        abortAt <= a;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(posedge clock);
        do @(posedge clock); while (request_stream_valid || linkValid);
        repeat (2) @(posedge clock);
        nulls = nullCount - null0;
        pulses = pulseCount - pulse0;
        outs = outCount - out0;
    endtask

    task automatic t_regs;
        wb(1'b0, `REG_CTRL, 4'hF, 32'h0, rd);
        `CHK("ctrl reset", 32'h0000_0000, rd)
        wb(1'b1, `REG_CTRL, 4'hF, 32'h0000_0002, rd);
        wb(1'b0, `REG_CTRL, 4'hF, 32'h0, rd);
        `CHK("ctrl", 32'h0000_0002, rd)
        wb(1'b1, `REG_CTRL, 4'hE, 32'hFFFF_FFFF, rd);
        wb(1'b0, `REG_CTRL, 4'hF, 32'h0, rd);
        `CHK("ctrl lanes", 32'hFFFF_FF02, rd)
        wb(1'b0, 8'h40, 4'hF, 32'h0, rd);
        `CHK("unmapped", 32'h0000_0000, rd)
        $display("regs done");
    endtask

    task automatic t_hint;
        stall <= 1'b1;
        send({1'b1, 2'h2, 3'h1}, 3'h3, 3'h0);
        `CHK("hint header", 6'h31, hdrSeen)
        `CHK("first payload", {8{32'hC0DE_0001}}, payloadSeen)
        `CHK("beats out", 3, outs)
        `CHK("no nullify", 0, nulls)
        `CHK("no report", 0, pulses)
        stall <= 1'b0;
        wb(1'b0, `REG_HEADER, 4'hF, 32'h0, rd);
        `CHK("header reg", 32'h0000_0031, rd)
        $display("hint done");
    endtask

    task automatic t_nohint;
        wb(1'b1, `REG_CTRL, 4'hF, 32'h0, rd);
        send({1'b0, 2'h3, 3'h0}, 3'h2, 3'h0);
        `CHK("masked header", 6'h00, hdrSeen)
        `CHK("beats out", 2, outs)
        $display("nohint done");
    endtask

    task automatic t_abort;
        wb(1'b1, `REG_CTRL, 4'hF, 32'h0000_0001, rd);
        stall <= 1'b1;
        send('0, 3'h3, 3'h2);
        `CHK("nullified", 2, nulls)
        `CHK("first beat", 1'b0, firstNull)
        `CHK("error report", 1, pulses)
        `CHK("beats out", 3, outs)
        stall <= 1'b0;
        wb(1'b0, `REG_COUNT, 4'hF, 32'h0, rd);
        `CHK("abort count", 32'h0000_0001, rd)
        wb(1'b0, `REG_STATUS, 4'hF, 32'h0, rd);
        `CHK("status", 32'h0000_0008, rd)
        $display("abort done");
    endtask

    task automatic wrapUp;
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #100000;
        badCount++;
        wrapUp;
    end
    initial begin
        rst_b = 1'b0;
        {go, stall, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} = '0;
        {hdr, beats, abortAt} = '0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        t_regs;
        t_hint;
        t_nohint;
        t_abort;
        wrapUp;
    end
endmodule
